/* File: hw/interrupt_priority_arbiter.sv */
// interrupt priority arbiter: node control, arbitration, vectored dispatch
// assumes peripherals pulse srcReq on clk, traps arrive from pins, cpu acks dispatch
`timescale 1ns/10ps
module interrupt_priority_arbiter #(
  parameter int NODES      = 128,  // implemented nodes
  parameter int MULTI_NODE = 0,    // node fed by several sources
  parameter int MULTI_SRCS = 4     // extra sources of that node
) (
  input  wire logic                      clk,             // system clock
  input  wire logic                      srst,            // synchronous reset, high
  input  wire logic [9:0]                avAddress,       // avalon byte address
  input  wire logic                      avRead,          // avalon read
  input  wire logic                      avWrite,         // avalon write
  input  wire logic [31:0]               avWritedata,     // avalon write data
  input  wire logic [3:0]                avByteenable,    // avalon byte lanes
  output logic [31:0]                    avReaddata,      // avalon read data
  output logic                           avWaitrequest,   // avalon wait
  input  wire logic [NODES-1:0]          srcReq,          // one-cycle request per node
  input  wire logic [MULTI_SRCS-1:0]     multiSrcReq,     // extra sources of the multi node
  input  wire logic [irq_arb_pkg::TRAP_N-1:0] trapPin,    // hardware traps, async pins
  output logic                           dispatchReq,     // winner acceptable now
  input  wire logic                      dispatchAck,     // cpu takes the winner
  output logic [irq_arb_pkg::NODE_W-1:0] winNode,         // winner node or trap number
  output logic [irq_arb_pkg::LEVEL_W-1:0] winLevel,       // winner level
  output irq_arb_pkg::action_t           winAction,       // requested action
  output logic [irq_arb_pkg::ADDR_W-1:0] winTarget,       // branch target
  output logic [irq_arb_pkg::LEVEL_W-1:0] cpuLevel,       // current cpu level
  output logic                           cpuHalt,         // event transfer running
  input  wire logic                      xferDone,        // event transfer finished
  output logic                           arbIdle          // arbitration idle
);
  localparam int SUB_W = (NODES > irq_arb_pkg::SUB_SPLIT_NODES) ? irq_arb_pkg::SUB_W_MAX
                                                                : irq_arb_pkg::SUB_W_SMALL;
  localparam logic [irq_arb_pkg::SUB_W_MAX-1:0] SUB_MASK = irq_arb_pkg::SUB_W_MAX'((1 << SUB_W) - 1);
  localparam int IDX_W = (NODES > 1) ? $clog2(NODES) : 1;
  localparam int KW    = irq_arb_pkg::KEY_W;
  localparam int AW    = irq_arb_pkg::ADDR_W;
  localparam int TN    = irq_arb_pkg::TRAP_N;

  typedef enum logic [1:0] {S_IDLE, S_ARB, S_PRESENT, S_XFER} fsm_t;
  typedef struct packed {
    logic                              flag;
    logic                              en;
    logic [irq_arb_pkg::LEVEL_W-1:0]   level;
    logic [irq_arb_pkg::SUB_W_MAX-1:0] sub;
    logic                              xfer;
  } node_t;
  typedef struct packed {
    logic [irq_arb_pkg::NODE_W-1:0] node;
    logic                           valid;
    logic [AW-1:0]                  addr;
  } cache_t;
  typedef struct packed {
    node_t  [NODES-1:0]                 node;
    cache_t [irq_arb_pkg::FAST_ENTRIES-1:0] cache;
    logic   [irq_arb_pkg::LEVEL_W-1:0]  cpuLevel;
    logic   [AW-1:0]                    vecBase;
    logic   [TN-1:0]                    trapMeta;
    logic   [TN-1:0]                    trapSync;
    logic   [TN-1:0]                    trapPrev;
    logic   [TN-1:0]                    trapPend;
    fsm_t                               fsm;
    logic   [irq_arb_pkg::NODE_W-1:0]   winNode;
    logic   [irq_arb_pkg::LEVEL_W-1:0]  winLevel;
    irq_arb_pkg::action_t               winAction;
    logic   [AW-1:0]                    winTarget;
    logic                               busAck;
    logic   [31:0]                      rdata;
  } state_t;

  state_t              st;
  state_t              next_st;
  logic [NODES-1:0]    cand;
  logic [NODES*KW-1:0] keys;
  logic                found;
  logic [IDX_W-1:0]    selIdx;
  logic [KW-1:0]       selKey;
  logic                accept;
  logic [IDX_W-1:0]    wIdx;
  logic [31:0]         rdVal;
  logic [31:0]         wVal;
  logic [31:0]         beMask;
  logic                swWr;
  logic [IDX_W-1:0]    regIdx;

  function automatic logic [AW-1:0] vecOf(input logic [AW-1:0] base, input int slot);
    return base + AW'(slot * irq_arb_pkg::VEC_STRIDE);
  endfunction

  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      cand[i]         = st.node[i].flag & st.node[i].en;
      keys[i*KW +: KW] = {st.node[i].level, st.node[i].sub & SUB_MASK};
    end
  end

  prio_select #(
    .N     (NODES),
    .KW    (KW),
    .IDX_W (IDX_W)
  ) u_select (
    .cand    (cand),
    .keys    (keys),
    .found   (found),
    .bestIdx (selIdx),
    .bestKey (selKey)
  );

  assign wIdx   = st.winNode[IDX_W-1:0];
  assign swWr   = avWrite & st.busAck;
  assign regIdx = avAddress[IDX_W+1:2];

  always_comb begin
    accept = 1'b0;
    if (st.fsm == S_PRESENT) begin
      if (st.winAction == irq_arb_pkg::ACT_TRAP) begin
        accept = st.trapPend[st.winNode[$clog2(TN)-1:0]];
      end else begin
        accept = st.node[wIdx].flag && st.node[wIdx].en && st.node[wIdx].level == st.winLevel
                 && st.winLevel > st.cpuLevel;
      end
    end
  end

  // register read mux
  always_comb begin
    rdVal = 32'h0;
    if (avAddress < irq_arb_pkg::OFF_CPU_LEVEL) begin
      if (int'(regIdx) < NODES && avAddress[8:2] == 7'(regIdx)) begin
        rdVal[irq_arb_pkg::CTL_FLAG_BIT]                     = st.node[regIdx].flag;
        rdVal[irq_arb_pkg::CTL_EN_BIT]                       = st.node[regIdx].en;
        rdVal[irq_arb_pkg::CTL_LVL_LSB +: irq_arb_pkg::LEVEL_W] = st.node[regIdx].level;
        rdVal[irq_arb_pkg::CTL_SUB_LSB +: irq_arb_pkg::SUB_W_MAX] = st.node[regIdx].sub & SUB_MASK;
        rdVal[irq_arb_pkg::CTL_XFER_BIT]                     = st.node[regIdx].xfer;
      end
    end else begin
      case (avAddress)
        irq_arb_pkg::OFF_CPU_LEVEL:  rdVal[irq_arb_pkg::LEVEL_W-1:0] = st.cpuLevel;
        irq_arb_pkg::OFF_STATUS: begin
          rdVal[irq_arb_pkg::ST_BUSY_BIT]                       = st.fsm != S_IDLE;
          rdVal[irq_arb_pkg::ST_REQ_BIT]                        = accept;
          rdVal[irq_arb_pkg::ST_NODE_LSB +: irq_arb_pkg::NODE_W] = st.winNode;
          rdVal[irq_arb_pkg::ST_LVL_LSB +: irq_arb_pkg::LEVEL_W] = st.winLevel;
          rdVal[irq_arb_pkg::ST_ACT_LSB +: 2]                   = st.winAction;
        end
        irq_arb_pkg::OFF_VEC_BASE:   rdVal[AW-1:0] = st.vecBase;
        irq_arb_pkg::OFF_CACHE0_CTL: rdVal = 32'({st.cache[0].valid, 1'b0, st.cache[0].node});
        irq_arb_pkg::OFF_CACHE0_ADR: rdVal[AW-1:0] = st.cache[0].addr;
        irq_arb_pkg::OFF_CACHE1_CTL: rdVal = 32'({st.cache[1].valid, 1'b0, st.cache[1].node});
        irq_arb_pkg::OFF_CACHE1_ADR: rdVal[AW-1:0] = st.cache[1].addr;
        default:                     rdVal = 32'h0;
      endcase
    end
    for (int b = 0; b < 4; b++) begin
      beMask[b*8 +: 8] = {8{avByteenable[b]}};
    end
    wVal = (rdVal & ~beMask) | (avWritedata & beMask);
  end

  always_comb begin
    next_st = st;
    // one wait state: data is ready and the write lands on the second edge
    next_st.busAck = (avRead | avWrite) & ~st.busAck;
    next_st.rdata  = st.busAck ? st.rdata : rdVal;

    if (swWr) begin
      if (avAddress < irq_arb_pkg::OFF_CPU_LEVEL) begin
        if (int'(regIdx) < NODES && avAddress[8:2] == 7'(regIdx)) begin
          next_st.node[regIdx].flag  = wVal[irq_arb_pkg::CTL_FLAG_BIT];
          next_st.node[regIdx].en    = wVal[irq_arb_pkg::CTL_EN_BIT];
          next_st.node[regIdx].level = wVal[irq_arb_pkg::CTL_LVL_LSB +: irq_arb_pkg::LEVEL_W];
          // unused sub bits forced to zero
          next_st.node[regIdx].sub  = wVal[irq_arb_pkg::CTL_SUB_LSB +: irq_arb_pkg::SUB_W_MAX] & SUB_MASK;
          next_st.node[regIdx].xfer = wVal[irq_arb_pkg::CTL_XFER_BIT];
        end
      end else begin
        case (avAddress)
          irq_arb_pkg::OFF_CPU_LEVEL:  next_st.cpuLevel = wVal[irq_arb_pkg::LEVEL_W-1:0];
          irq_arb_pkg::OFF_VEC_BASE:   next_st.vecBase  = wVal[AW-1:0];
          irq_arb_pkg::OFF_CACHE0_CTL: begin
            next_st.cache[0].node  = wVal[irq_arb_pkg::CC_NODE_LSB +: irq_arb_pkg::NODE_W];
            next_st.cache[0].valid = wVal[irq_arb_pkg::CC_VALID_BIT];
          end
          irq_arb_pkg::OFF_CACHE0_ADR: next_st.cache[0].addr = wVal[AW-1:0];
          irq_arb_pkg::OFF_CACHE1_CTL: begin
            next_st.cache[1].node  = wVal[irq_arb_pkg::CC_NODE_LSB +: irq_arb_pkg::NODE_W];
            next_st.cache[1].valid = wVal[irq_arb_pkg::CC_VALID_BIT];
          end
          irq_arb_pkg::OFF_CACHE1_ADR: next_st.cache[1].addr = wVal[AW-1:0];
          default: ;
        endcase
      end
    end

    // trap pins: two flops, then edge into a sticky pending bit
    next_st.trapMeta = trapPin;
    next_st.trapSync = st.trapMeta;
    next_st.trapPrev = st.trapSync;

    unique case (st.fsm)
      S_IDLE: begin
        if ((|cand) || (|st.trapPend)) begin
          next_st.fsm = S_ARB;
        end
      end
      S_ARB: begin
        next_st.fsm = S_PRESENT;
        if (|st.trapPend) begin
          next_st.winAction = irq_arb_pkg::ACT_TRAP;
          next_st.winLevel  = '1;
          for (int t = TN - 1; t >= 0; t--) begin
            if (st.trapPend[t]) begin
              next_st.winNode   = irq_arb_pkg::NODE_W'(t);
              // trap slots follow the reset slot
              next_st.winTarget = vecOf(st.vecBase, irq_arb_pkg::TRAP_SLOT0 + t);
            end
          end
        end else if (found) begin
          next_st.winNode   = irq_arb_pkg::NODE_W'(selIdx);
          next_st.winLevel  = selKey[KW-1 -: irq_arb_pkg::LEVEL_W];
          // node vector in the jump table
          next_st.winAction = irq_arb_pkg::ACT_NORMAL;
          next_st.winTarget = vecOf(st.vecBase, irq_arb_pkg::NODE_SLOT0 + int'(selIdx));
          if (st.node[selIdx].xfer) begin
            next_st.winAction = irq_arb_pkg::ACT_XFER;
          end else if (selKey[KW-1 -: irq_arb_pkg::LEVEL_W] >= irq_arb_pkg::FAST_LEVEL_MIN) begin
            for (int c = irq_arb_pkg::FAST_ENTRIES - 1; c >= 0; c--) begin
              if (st.cache[c].valid && st.cache[c].node == irq_arb_pkg::NODE_W'(selIdx)) begin
                next_st.winAction = irq_arb_pkg::ACT_FAST;
                next_st.winTarget = st.cache[c].addr;
              end
            end
          end
        end else begin
          next_st.fsm = S_IDLE;
        end
      end
      S_PRESENT: begin
        if (!accept) begin
          next_st.fsm = S_ARB;
        end else if (dispatchAck) begin
          next_st.fsm = S_ARB;
          if (st.winAction == irq_arb_pkg::ACT_TRAP) begin
            next_st.trapPend[st.winNode[$clog2(TN)-1:0]] = 1'b0;
          end else begin
            next_st.node[wIdx].flag = 1'b0;
            if (st.winAction == irq_arb_pkg::ACT_XFER) begin
              next_st.fsm = S_XFER;
            end else begin
              next_st.cpuLevel = st.winLevel;
            end
          end
        end
      end
      S_XFER: begin
        if (xferDone) begin
          next_st.fsm = S_ARB;
        end
      end
    endcase

    // new events win over any clear in the same cycle
    next_st.trapPend = next_st.trapPend | (st.trapSync & ~st.trapPrev);
    for (int i = 0; i < NODES; i++) begin
      if (srcReq[i] || (i == MULTI_NODE && (|multiSrcReq))) begin
        next_st.node[i].flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st          <= '0;
      st.cpuLevel <= irq_arb_pkg::CPU_LEVEL_RST;
      st.vecBase  <= irq_arb_pkg::VEC_BASE_RST;
      st.fsm      <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign avWaitrequest = (avRead | avWrite) & ~st.busAck;
  assign avReaddata    = st.rdata;
  assign dispatchReq   = accept;
  assign winNode       = st.winNode;
  assign winLevel      = st.winLevel;
  assign winAction     = st.winAction;
  assign winTarget     = st.winTarget;
  assign cpuLevel      = st.cpuLevel;
  assign cpuHalt       = st.fsm == S_XFER;
  assign arbIdle       = st.fsm == S_IDLE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_accept_level;
    dispatchReq && winAction != irq_arb_pkg::ACT_TRAP |-> winLevel > cpuLevel;
  endproperty
  a_accept_level: assert property (p_accept_level) else $error("dispatch at or below cpu level");

  property p_refused_stays;
    st.fsm == S_PRESENT && winAction != irq_arb_pkg::ACT_TRAP && st.node[wIdx].flag
      && st.winLevel <= st.cpuLevel && !swWr |=> st.node[wIdx].flag;
  endproperty
  a_refused_stays: assert property (p_refused_stays) else $error("refused request lost its flag");

  property p_wake;
    arbIdle && (|cand) |=> st.fsm == S_ARB ##1 st.fsm == S_PRESENT;
  endproperty
  a_wake: assert property (p_wake) else $error("pending node did not start arbitration");

  property p_trap_first;
    st.fsm == S_ARB && (|st.trapPend) |=> winAction == irq_arb_pkg::ACT_TRAP;
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trap lost against a level");

  property p_fast_level;
    winAction == irq_arb_pkg::ACT_FAST |-> winLevel >= irq_arb_pkg::FAST_LEVEL_MIN;
  endproperty
  a_fast_level: assert property (p_fast_level) else $error("fast dispatch below level 12");

  property p_fast_target;
    dispatchReq && winAction == irq_arb_pkg::ACT_FAST |->
      (winTarget == st.cache[0].addr && st.cache[0].node == winNode)
      || (winTarget == st.cache[1].addr && st.cache[1].node == winNode);
  endproperty
  a_fast_target: assert property (p_fast_target) else $error("fast target not from cache");

  property p_vector;
    dispatchReq && winAction == irq_arb_pkg::ACT_NORMAL |->
      winTarget == vecOf(st.vecBase, irq_arb_pkg::NODE_SLOT0 + int'(wIdx));
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match node");

  property p_enabled_only;
    dispatchReq && winAction != irq_arb_pkg::ACT_TRAP |-> st.node[wIdx].en && st.node[wIdx].flag;
  endproperty
  a_enabled_only: assert property (p_enabled_only) else $error("disabled node dispatched");

  property p_xfer_halt;
    dispatchReq && dispatchAck && winAction == irq_arb_pkg::ACT_XFER |=>
      cpuHalt && cpuLevel == $past(cpuLevel);
  endproperty
  a_xfer_halt: assert property (p_xfer_halt) else $error("transfer did not halt or changed level");

  property p_level_update;
    dispatchReq && dispatchAck && (winAction == irq_arb_pkg::ACT_NORMAL || winAction == irq_arb_pkg::ACT_FAST)
      |=> cpuLevel == $past(winLevel) && !arbIdle;
  endproperty
  a_level_update: assert property (p_level_update) else $error("cpu level not raised on accept");
endmodule

/* File: hw/irq_arb_pkg.sv */
// constants shared by the interrupt priority arbiter and its tests
// assumes one system clock; registers reached over a 32-bit avalon-mm slave
package irq_arb_pkg;
  // node count, levels, sub-priorities and fast vector cache
  localparam int            NODE_MAX        = 128;
  localparam int            NODE_W          = 7;
  localparam int            LEVEL_W         = 4;
  localparam int            SUB_W_MAX       = 3;
  localparam int            SUB_W_SMALL     = 2;
  localparam int            SUB_SPLIT_NODES = 64;
  localparam int            KEY_W           = LEVEL_W + SUB_W_MAX;
  localparam logic [3:0]    FAST_LEVEL_MIN  = 4'hc;
  localparam int            FAST_ENTRIES    = 2;
  localparam int            ADDR_W          = 24;
  localparam int            TRAP_N          = 4;
  // jump table layout: slot 0 reset, then traps, then nodes
  localparam int            VEC_STRIDE      = 4;
  localparam int            RESET_SLOT      = 0;
  localparam int            TRAP_SLOT0      = 1;
  localparam int            NODE_SLOT0      = TRAP_SLOT0 + TRAP_N;
  // avalon byte addresses
  localparam int            AV_ADDR_W       = 10;
  localparam logic [9:0]    OFF_NODE_BASE   = 10'h000;
  localparam logic [9:0]    OFF_CPU_LEVEL   = 10'h200;
  localparam logic [9:0]    OFF_STATUS      = 10'h204;
  localparam logic [9:0]    OFF_VEC_BASE    = 10'h208;
  localparam logic [9:0]    OFF_CACHE0_CTL  = 10'h20c;
  localparam logic [9:0]    OFF_CACHE0_ADR  = 10'h210;
  localparam logic [9:0]    OFF_CACHE1_CTL  = 10'h214;
  localparam logic [9:0]    OFF_CACHE1_ADR  = 10'h218;
  // node control register fields
  localparam int            CTL_FLAG_BIT    = 0;
  localparam int            CTL_EN_BIT      = 1;
  localparam int            CTL_LVL_LSB     = 2;
  localparam int            CTL_SUB_LSB     = 6;
  localparam int            CTL_XFER_BIT    = 9;
  // status and cache control fields
  localparam int            ST_BUSY_BIT     = 0;
  localparam int            ST_REQ_BIT      = 1;
  localparam int            ST_NODE_LSB     = 2;
  localparam int            ST_LVL_LSB      = 9;
  localparam int            ST_ACT_LSB      = 13;
  localparam int            CC_NODE_LSB     = 0;
  localparam int            CC_VALID_BIT    = 8;
  // reset values
  localparam logic [3:0]    CPU_LEVEL_RST   = 4'h0;
  localparam logic [23:0]   VEC_BASE_RST    = 24'h000000;

  typedef enum logic [1:0] {ACT_NORMAL, ACT_XFER, ACT_FAST, ACT_TRAP} action_t;
endpackage

/* File: hw/prio_select.sv */
// picks the candidate with the largest key; ties go to the lowest index
// assumes keys packed low index first, purely combinational
`timescale 1ns/10ps
module prio_select #(
  parameter int N     = 128,
  parameter int KW    = 7,
  parameter int IDX_W = 7
) (
  input  wire logic [N-1:0]    cand,     // candidate present
  input  wire logic [N*KW-1:0] keys,     // ranking key per candidate
  output logic                 found,    // any candidate
  output logic [IDX_W-1:0]     bestIdx,  // winning index
  output logic [KW-1:0]        bestKey   // winning key
);
  always_comb begin
    found   = 1'b0;
    bestIdx = '0;
    bestKey = '0;
    for (int i = 0; i < N; i++) begin
      if (cand[i] && (!found || keys[i*KW +: KW] > bestKey)) begin
        found   = 1'b1;
        bestIdx = IDX_W'(i);
        bestKey = keys[i*KW +: KW];
      end
    end
  end
endmodule

/* File: test/cpu_model.sv */
// cpu side model: takes dispatch offers and ends event transfers
// assumes clk with srst synchronous active high; ack delay set by the bench
`timescale 1ns/10ps
module cpu_model (
  input  wire logic                 clk,         // system clock
  input  wire logic                 srst,        // sync reset
  input  wire logic [3:0]           ackDelay,    // offer cycles before taking
  input  wire logic                 dispatchReq, // winner offered
  input  wire logic [6:0]           winNode,     // offered node
  input  wire irq_arb_pkg::action_t winAction,   // offered action
  input  wire logic [23:0]          winTarget,   // offered target
  input  wire logic                 cpuHalt,     // transfer running
  output logic                      dispatchAck, // take the winner
  output logic                      xferDone,    // transfer finished
  output logic [7:0]                ackCnt,      // winners taken
  output logic [6:0]                gotNode,     // last node taken
  output irq_arb_pkg::action_t      gotAct,      // last action taken
  output logic [23:0]               gotTgt       // last target taken
);
  logic [3:0] waitCnt;
  logic [1:0] hCnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      dispatchAck <= 1'b0;
      xferDone <= 1'b0;
      ackCnt <= 8'h00;
      waitCnt <= 4'h0;
      hCnt <= 2'h0;
    end else begin
      dispatchAck <= 1'b0;
      xferDone <= 1'b0;
      if (dispatchAck && dispatchReq) begin
        gotNode <= winNode;
        gotAct <= winAction;
        gotTgt <= winTarget;
        ackCnt <= ackCnt + 8'h01;
        waitCnt <= 4'h0;
      end else if (dispatchReq) begin
        if (waitCnt >= ackDelay) dispatchAck <= 1'b1;
        else waitCnt <= waitCnt + 4'h1;
      end else waitCnt <= 4'h0;
      // finish the transfer after a short halt
      if (cpuHalt && !xferDone) begin
        hCnt <= hCnt + 2'h1;
        if (hCnt == 2'h2) xferDone <= 1'b1;
      end else hCnt <= 2'h0;
    end
  end
endmodule

/* File: test/interrupt_priority_arbiter_tb_top.sv */
// bench for the interrupt priority arbiter: register tasks, pulses, dispatch checks
// assumes cpu_model as far side and the package constants
`timescale 1ns/10ps
`define CHK(n,e,g) begin tests_run++; if ((g)!==(e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module interrupt_priority_arbiter_tb_top;
  logic clk = 0, srst = 1, avRead = 0, avWrite = 0, avWaitrequest, dispatchReq, dispatchAck;
  logic [9:0] avAddress = '0;
  logic [31:0] avWritedata = '0, avReaddata, q;
  logic [127:0] srcReq = '0;
  logic [3:0] multiSrcReq = '0, trapPin = '0, ackDelay = 0, winLevel, cpuLevel;
  logic [3:0] avByteenable = 4'hf, beSel = 4'hf;
  logic [6:0] winNode, gotNode;
  logic [23:0] winTarget, gotTgt;
  logic [7:0] ackCnt, seen = 0;
  logic cpuHalt, xferDone, arbIdle;
  irq_arb_pkg::action_t winAction, gotAct;
  int num_errors = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  interrupt_priority_arbiter DUT (.clk(clk), .srst(srst), .avAddress(avAddress), .avRead(avRead),
    .avWrite(avWrite), .avWritedata(avWritedata), .avByteenable(avByteenable), .avReaddata(avReaddata),
    .avWaitrequest(avWaitrequest), .srcReq(srcReq), .multiSrcReq(multiSrcReq), .trapPin(trapPin),
    .dispatchReq(dispatchReq), .dispatchAck(dispatchAck), .winNode(winNode), .winLevel(winLevel),
    .winAction(winAction), .winTarget(winTarget), .cpuLevel(cpuLevel), .cpuHalt(cpuHalt),
    .xferDone(xferDone), .arbIdle(arbIdle));
  cpu_model cpu (.clk(clk), .srst(srst), .ackDelay(ackDelay), .dispatchReq(dispatchReq),
    .winNode(winNode), .winAction(winAction), .winTarget(winTarget), .cpuHalt(cpuHalt),
    .dispatchAck(dispatchAck), .xferDone(xferDone), .ackCnt(ackCnt), .gotNode(gotNode),
    .gotAct(gotAct), .gotTgt(gotTgt));
  task automatic av(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avAddress <= a;
    avWrite <= w;
    avRead <= !w;
    avWritedata <= d;
    avByteenable <= beSel;
    // hold the request until waitrequest is sampled low at a rising edge
    do begin @(posedge clk); n++; end while (avWaitrequest !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    q = avReaddata;
    avRead <= 1'b0;
    avWrite <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string s);
    av(1'b0, a, 32'h0);
    `CHK(s, e, q)
  endtask
  // waits for the next winner taken by the cpu model, then checks it
  task automatic win(input logic [6:0] n, input irq_arb_pkg::action_t a, input logic [23:0] t);
    int c;
    c = 0;
    seen = seen + 8'h01;
    while (ackCnt !== seen && c < 300) begin @(negedge clk); c++; end
    if (c >= 300) num_errors++;
    `CHK("node", n, gotNode)
    `CHK("action", a, gotAct)
    `CHK("target", t, gotTgt)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #50us;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(10'h200, 32'h0, "cpuLevel");
    rd(10'h204, 32'h0, "status");
    rd(10'h014, 32'h0, "node5");
    rd(10'h3fc, 32'h0, "unmapped");
    $display("reset test done");
    av(1'b1, 10'h014, 32'h0e);
    av(1'b1, 10'h024, 32'h8e);
    @(posedge clk) srcReq <= 128'h220;
    @(posedge clk) srcReq <= '0;
    win(7'd9, irq_arb_pkg::ACT_NORMAL, 24'h38);
    `CHK("cpuLevel", 4'h3, cpuLevel)
    rd(10'h014, 32'h0f, "node5 pending");
    rd(10'h204, 32'h615, "status refused");
    `CHK("winLevel", 4'h3, winLevel)
    av(1'b1, 10'h200, 32'h0);
    win(7'd5, irq_arb_pkg::ACT_NORMAL, 24'h28);
    av(1'b1, 10'h200, 32'h0);
    $display("level test done");
    av(1'b1, 10'h208, 32'h1000);
    av(1'b1, 10'h01c, 32'h20a);
    @(posedge clk) srcReq[7] <= 1'b1;
    @(posedge clk) srcReq <= '0;
    win(7'd7, irq_arb_pkg::ACT_XFER, 24'h1030);
    `CHK("cpuHalt", 1'b1, cpuHalt)
    `CHK("cpuLevel", 4'h0, cpuLevel)
    av(1'b1, 10'h054, 32'h2e);
    av(1'b1, 10'h20c, 32'h115);
    av(1'b1, 10'h210, 32'h0abcde);
    av(1'b1, 10'h050, 32'h32);
    av(1'b1, 10'h214, 32'h114);
    av(1'b1, 10'h218, 32'h123456);
    @(posedge clk) srcReq[21] <= 1'b1;
    @(posedge clk) srcReq <= '0;
    win(7'd21, irq_arb_pkg::ACT_NORMAL, 24'h1068);
    av(1'b1, 10'h200, 32'h0);
    @(posedge clk) srcReq[20] <= 1'b1;
    @(posedge clk) srcReq <= '0;
    win(7'd20, irq_arb_pkg::ACT_FAST, 24'h123456);
    `CHK("cpuLevel", 4'hc, cpuLevel)
    $display("action test done");
    ackDelay <= 4'h4;
    @(posedge clk) trapPin[1] <= 1'b1;
    repeat (3) @(posedge clk);
    trapPin <= '0;
    win(7'd1, irq_arb_pkg::ACT_TRAP, 24'h1008);
    `CHK("cpuLevel", 4'hc, cpuLevel)
    av(1'b1, 10'h200, 32'h0);
    av(1'b1, 10'h000, 32'h06);
    @(posedge clk) multiSrcReq[2] <= 1'b1;
    @(posedge clk) multiSrcReq <= '0;
    win(7'd0, irq_arb_pkg::ACT_NORMAL, 24'h1014);
    repeat (6) @(posedge clk);
    `CHK("arbIdle", 1'b1, arbIdle)
    beSel = 4'h2;
    av(1'b1, 10'h000, 32'hffffffff);
    beSel = 4'hf;
    rd(10'h000, 32'h306, "node0 lanes");
    $display("trap test done");
    test_done;
  end
endmodule
